/* rtcc_pkg.sv */
// Constants and types of the real-time counter control register block
package rtcc_pkg;

  // Byte offsets of the register words
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] FLAG_OFS = 8'h08;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h20;
  localparam logic [7:0] IRQ_EN_OFS = 8'h24;

  // Control register fields
  localparam int SOFTWARE_RESET_BIT = 0;
  localparam int ENABLE_BIT = 1;
  localparam int MODE_LSB = 2;
  localparam int HOUR_FMT_BIT = 6;
  localparam int MATCH_CLR_BIT = 7;
  localparam int PRESC_LSB = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [3:0] PRESC_MAX = 4'hA;

  // Flag word: flag byte 0, status byte 2, debug byte 3
  localparam int SYNC_RDY_BIT = 6;
  localparam int SYNC_BUSY_BIT = 23;
  localparam int DBG_RUN_BIT = 24;

  // Timing counts in clk_sys cycles
  localparam logic [2:0] SYNC_LAT_CYC = 3'h4;
  localparam logic [3:0] SRC_DIV_CYC = 4'h2;

  typedef enum logic [1:0] {
    MODE_WIDE = 2'b00,
    MODE_NARROW = 2'b01,
    MODE_CALENDAR = 2'b10,
    MODE_RESERVED = 2'b11
  } rtcc_mode_e;

  typedef enum logic [1:0] {
    SYNC_IDLE = 2'b00,
    SYNC_ENABLE = 2'b01,
    SYNC_RESET = 2'b10
  } rtcc_sync_e;

endpackage

/* rtcc_ctrl.sv */
// Control register, synchronization and prescaler of the real-time counter
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
module rtcc_ctrl
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [3:0] byte_en,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Protection
  input wire logic peripheral_write_guard,
  // Counter side
  input wire logic match_hit,
  output logic counter_enable,
  output logic counter_clock,
  output logic counter_clear,
  output logic regs_reset,
  output logic [1:0] mode,
  output logic hour_12h,
  output logic debug_run,
  // Interrupt
  output logic irq
);

  typedef struct packed {
    logic [3:0] presc;
    logic match_clr;
    logic hour_fmt;
    logic [1:0] mode;
    logic en_rd;
    logic rst_rd;
    logic active;
    logic busy;
    rtcc_pkg::rtcc_sync_e sync;
    logic [2:0] sync_cnt;
    logic pend_v;
    logic pend_rst;
    logic [3:0] src_cnt;
    logic [9:0] pre_cnt;
    logic cnt_tick;
    logic cnt_clr;
    logic regs_rst;
    logic hr12;
    logic rdy_flag;
    logic rdy_en;
    logic dbg_run;
    logic irq;
    logic [31:0] rdata;
  } rtcc_state_s;

  rtcc_state_s s_q;
  rtcc_state_s s_d;

  logic wr_ok;
  logic guarded;
  logic ctrl_wr;
  logic rst_req;
  logic en_req;
  logic src_tick;
  logic done;
  logic [3:0] presc_eff;
  logic [9:0] tick_mask;
  logic [15:0] ctrl_rd;

  // Enable-protection looks at both the written and the live enable,
  // so fields stay locked through a pending disable as well
  assign wr_ok = wr & ~peripheral_write_guard;
  assign guarded = s_q.en_rd | s_q.active;
  assign ctrl_wr = wr_ok & (addr == rtcc_pkg::CTRL_OFS);
  assign rst_req = ctrl_wr & byte_en[0] & wdata[rtcc_pkg::SOFTWARE_RESET_BIT];
  assign en_req = ctrl_wr & byte_en[0] & ~rst_req;
  assign src_tick = (s_q.src_cnt == rtcc_pkg::SRC_DIV_CYC - 4'h1);
  assign done = (s_q.sync != rtcc_pkg::SYNC_IDLE) &&
                (s_q.sync_cnt == rtcc_pkg::SYNC_LAT_CYC - 3'h1);
  // Reserved codes behave as the largest division
  assign presc_eff = (s_q.presc > rtcc_pkg::PRESC_MAX) ?
                     rtcc_pkg::PRESC_MAX : s_q.presc;
  assign tick_mask = ~(10'h3FF << presc_eff);

  always_comb
  begin
    ctrl_rd = 16'h0000;
    ctrl_rd[rtcc_pkg::PRESC_LSB +: 4] = s_q.presc;
    ctrl_rd[rtcc_pkg::MATCH_CLR_BIT] = s_q.match_clr;
    ctrl_rd[rtcc_pkg::HOUR_FMT_BIT] = s_q.hour_fmt &
      (s_q.mode == rtcc_pkg::MODE_CALENDAR);
    ctrl_rd[rtcc_pkg::MODE_LSB +: 2] = s_q.mode;
    ctrl_rd[rtcc_pkg::ENABLE_BIT] = s_q.en_rd;
    ctrl_rd[rtcc_pkg::SOFTWARE_RESET_BIT] = s_q.rst_rd;
  end

  always_comb
  begin
    s_d = s_q;
    s_d.cnt_tick = 1'b0;
    s_d.cnt_clr = 1'b0;
    s_d.regs_rst = 1'b0;
    s_d.rdata = 32'h00000000;

    // Static fields: no handshake, per-lane, only while disabled
    if (ctrl_wr && !rst_req && !guarded)
    begin
      if (byte_en[1])
        s_d.presc = wdata[rtcc_pkg::PRESC_LSB +: 4];
      if (byte_en[0])
      begin
        s_d.mode = wdata[rtcc_pkg::MODE_LSB +: 2];
        s_d.match_clr = wdata[rtcc_pkg::MATCH_CLR_BIT];
        s_d.hour_fmt = wdata[rtcc_pkg::HOUR_FMT_BIT];
      end
    end

    // Synchronization progress
    if (s_q.sync != rtcc_pkg::SYNC_IDLE)
      s_d.sync_cnt = s_q.sync_cnt + 3'h1;

    // Enable and reset writes are accepted in any state; a write
    // during busy is held and replayed since this port never stalls
    if (rst_req)
    begin
      s_d.rst_rd = 1'b1;
      if (s_q.sync == rtcc_pkg::SYNC_IDLE)
      begin
        s_d.sync = rtcc_pkg::SYNC_RESET;
        s_d.sync_cnt = 3'h0;
        s_d.busy = 1'b1;
      end
      else
      begin
        s_d.pend_v = 1'b1;
        s_d.pend_rst = 1'b1;
      end
    end
    else if (en_req)
    begin
      s_d.en_rd = wdata[rtcc_pkg::ENABLE_BIT];
      if (s_q.sync == rtcc_pkg::SYNC_IDLE)
      begin
        s_d.sync = rtcc_pkg::SYNC_ENABLE;
        s_d.sync_cnt = 3'h0;
        s_d.busy = 1'b1;
      end
      else
        s_d.pend_v = 1'b1;
    end

    if (done)
    begin
      s_d.busy = 1'b0;
      s_d.sync = rtcc_pkg::SYNC_IDLE;
      s_d.sync_cnt = 3'h0;
      case (s_q.sync)
        rtcc_pkg::SYNC_ENABLE:
          s_d.active = s_q.en_rd;
        rtcc_pkg::SYNC_RESET:
        begin
          // Debug control survives and the ready flag is set; everything else returns to reset
          s_d.presc = rtcc_pkg::CTRL_RESET[rtcc_pkg::PRESC_LSB +: 4];
          s_d.mode = rtcc_pkg::CTRL_RESET[rtcc_pkg::MODE_LSB +: 2];
          s_d.match_clr = rtcc_pkg::CTRL_RESET[rtcc_pkg::MATCH_CLR_BIT];
          s_d.hour_fmt = rtcc_pkg::CTRL_RESET[rtcc_pkg::HOUR_FMT_BIT];
          // An enable written while the reset runs is kept for its replay
          s_d.en_rd = s_d.en_rd & s_d.pend_v & ~s_d.pend_rst;
          s_d.active = 1'b0;
          s_d.rst_rd = s_d.pend_rst;
          s_d.rdy_en = 1'b0;
          s_d.rdy_flag = 1'b0;
          s_d.regs_rst = 1'b1;
        end
        default:
          s_d.active = s_q.active;
      endcase
      s_d.rdy_flag = 1'b1;
      if (s_d.pend_v)
      begin
        s_d.sync = s_d.pend_rst ? rtcc_pkg::SYNC_RESET :
                   rtcc_pkg::SYNC_ENABLE;
        s_d.busy = 1'b1;
        s_d.pend_v = 1'b0;
        s_d.pend_rst = 1'b0;
      end
    end

    // Source clock enable and counter prescaler
    s_d.src_cnt = src_tick ? 4'h0 : s_q.src_cnt + 4'h1;
    if (!s_q.active)
      s_d.pre_cnt = 10'h000;
    else if (src_tick)
    begin
      s_d.pre_cnt = s_q.pre_cnt + 10'h001;
      s_d.cnt_tick = ((s_q.pre_cnt & tick_mask) == tick_mask);
    end

    // Narrow counter mode has no clear-on-match
    s_d.cnt_clr = s_q.active & s_q.match_clr & match_hit &
      (s_q.mode != rtcc_pkg::MODE_NARROW);
    s_d.hr12 = s_d.hour_fmt &
      (s_d.mode == rtcc_pkg::MODE_CALENDAR);

    // Interrupt registers; a set in the same cycle beats the clear
    if (wr_ok && addr == rtcc_pkg::IRQ_CLR_OFS && byte_en[0] &&
        wdata[rtcc_pkg::SYNC_RDY_BIT] && !done)
      s_d.rdy_flag = 1'b0;
    if (wr_ok && addr == rtcc_pkg::IRQ_EN_OFS && byte_en[0] && !rst_req)
      s_d.rdy_en = wdata[rtcc_pkg::SYNC_RDY_BIT];
    if (wr_ok && addr == rtcc_pkg::FLAG_OFS && byte_en[3])
      s_d.dbg_run = wdata[rtcc_pkg::DBG_RUN_BIT];
    s_d.irq = s_d.rdy_flag & s_d.rdy_en;

    // Read data, only in the cycle after the strobe
    if (rd)
    begin
      case (addr)
        rtcc_pkg::CTRL_OFS:
          s_d.rdata = {16'h0000, ctrl_rd};
        rtcc_pkg::FLAG_OFS:
        begin
          s_d.rdata[rtcc_pkg::SYNC_RDY_BIT] = s_q.rdy_flag;
          s_d.rdata[rtcc_pkg::SYNC_BUSY_BIT] = s_q.busy;
          s_d.rdata[rtcc_pkg::DBG_RUN_BIT] = s_q.dbg_run;
        end
        rtcc_pkg::IRQ_EN_OFS:
          s_d.rdata[rtcc_pkg::SYNC_RDY_BIT] = s_q.rdy_en;
        default:
          s_d.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_q <= '0;
      s_q.sync <= rtcc_pkg::SYNC_IDLE;
    end
    else
      s_q <= s_d;
  end

  assign rdata = s_q.rdata;
  assign counter_enable = s_q.active;
  assign counter_clock = s_q.cnt_tick;
  assign counter_clear = s_q.cnt_clr;
  assign regs_reset = s_q.regs_rst;
  assign mode = s_q.mode;
  assign hour_12h = s_q.hr12;
  assign debug_run = s_q.dbg_run;
  assign irq = s_q.irq;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  logic idle;
  assign idle = (s_q.sync == rtcc_pkg::SYNC_IDLE);

  sequence seq_start_enable;
    en_req && idle;
  endsequence

  sequence seq_busy_window;
    s_q.busy [*4];
  endsequence

  a_enable_busy: assert property
    (seq_start_enable |=> seq_busy_window)
    else $error("busy not held for the sync latency");

  a_enable_readback: assert property
    (en_req |=> s_q.en_rd == $past(wdata[rtcc_pkg::ENABLE_BIT]))
    else $error("enable write not visible at once");

  a_ready_on_done: assert property
    ($fell(s_q.busy) |-> s_q.rdy_flag)
    else $error("ready flag missing at sync completion");

  a_mode_locked: assert property
    (ctrl_wr && guarded && idle |=> $stable(s_q.mode))
    else $error("mode changed while enabled");

  a_fmt_locked: assert property
    (ctrl_wr && guarded && idle |=>
     $stable(s_q.hour_fmt) && $stable(s_q.match_clr))
    else $error("protected bit changed while enabled");

  a_static_no_sync: assert property
    (ctrl_wr && !byte_en[0] && idle |=> !s_q.busy)
    else $error("static field write raised busy");

  a_reset_discards: assert property
    (rst_req && idle |=> $stable(s_q.mode) && $stable(s_q.presc)
     && s_q.rst_rd)
    else $error("reset write changed other fields");

  a_reset_done: assert property
    ($fell(s_q.rst_rd) |-> $fell(s_q.busy) && s_q.mode == 2'b00 &&
     s_q.presc == 4'h0 && !s_q.active)
    else $error("reset completion not coherent");

  a_guard_blocks: assert property
    (wr && peripheral_write_guard && idle |=>
     $stable(s_q.en_rd) && $stable(s_q.presc) && $stable(s_q.rdy_en))
    else $error("guarded write took effect");

  a_div1_tick: assert property
    (s_q.active && s_q.presc == 4'h0 && src_tick |=> s_q.cnt_tick)
    else $error("divide by one missed a tick");

  a_match_clear: assert property
    (s_q.active && s_q.match_clr && match_hit &&
     s_q.mode != rtcc_pkg::MODE_NARROW |=> s_q.cnt_clr)
    else $error("clear on match not issued");

  a_hour_bit_zero: assert property
    (rd && addr == rtcc_pkg::CTRL_OFS &&
     s_q.mode != rtcc_pkg::MODE_CALENDAR |=>
     !s_q.rdata[rtcc_pkg::HOUR_FMT_BIT])
    else $error("hour format bit visible outside calendar");

  a_lane_only: assert property
    (ctrl_wr && !byte_en[1] && idle |=> $stable(s_q.presc))
    else $error("prescaler written without its byte lane");

  sequence seq_start_reset;
    rst_req && idle;
  endsequence

  a_reset_read_one: assert property
    (seq_start_reset |=> s_q.rst_rd [*4])
    else $error("reset bit not held while reset runs");

  a_reset_disables: assert property
    (done && s_q.sync == rtcc_pkg::SYNC_RESET |=>
     !s_q.active && s_q.regs_rst)
    else $error("software reset left the counter enabled");

  a_enable_done: assert property
    (done && s_q.sync == rtcc_pkg::SYNC_ENABLE |=>
     s_q.active == $past(s_q.en_rd))
    else $error("live enable does not follow written enable");

  a_presc_write: assert property
    (ctrl_wr && byte_en[1] && !rst_req && !guarded && idle |=>
     s_q.presc == $past(wdata[rtcc_pkg::PRESC_LSB +: 4]))
    else $error("prescaler write lost while disabled");

  a_no_tick_off: assert property
    (!s_q.active |=> !s_q.cnt_tick)
    else $error("counter clock pulse while disabled");

  a_narrow_no_clear: assert property
    (s_q.mode == rtcc_pkg::MODE_NARROW |=> !s_q.cnt_clr)
    else $error("clear on match issued in narrow mode");

  a_hour_out_cal: assert property
    (s_q.hr12 |-> s_q.mode == rtcc_pkg::MODE_CALENDAR)
    else $error("12 hour output outside calendar mode");

  a_rdata_idle_zero: assert property
    (!rd |=> s_q.rdata == 32'h00000000)
    else $error("read data outside the read cycle");

endmodule // rtcc_ctrl

/* rtcc_ctrl_tb.sv */
// Self-checking testbench of the real-time counter control block
`timescale 1ns/1ps
module rtcc_ctrl_tb;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] byte_en = 4'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic guard = 1'b0;
  logic match_hit = 1'b0;
  logic [31:0] rdata;
  logic counter_enable, counter_clock, counter_clear, regs_reset;
  logic [1:0] mode;
  logic hour_12h, debug_run, irq;
  logic [31:0] d;
  logic [3:0] codes [3] = '{4'h5, 4'h0, 4'hA};
  int failures = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;

  rtcc_ctrl i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .byte_en(byte_en), .wr(wr), .rd(rd), .rdata(rdata),
    .peripheral_write_guard(guard), .match_hit(match_hit),
    .counter_enable(counter_enable), .counter_clock(counter_clock),
    .counter_clear(counter_clear), .regs_reset(regs_reset), .mode(mode),
    .hour_12h(hour_12h), .debug_run(debug_run), .irq(irq)
  );

  always #20 clk_sys = ~clk_sys;

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Long enough for three prescaler periods at the largest divider
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v,
                        input logic [3:0] be);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    byte_en <= be;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic wait_en(input logic v);
    int k;
    k = 0;
    while (counter_enable !== v && k < 20)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    check("counter_enable", {31'h0, counter_enable}, {31'h0, v});
  endtask

  task automatic period(output int p);
    int k;
    k = 0;
    while (counter_clock !== 1'b1 && k < 3000)
    begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    @(posedge clk_sys);
    #1;
    p = 1;
    while (counter_clock !== 1'b1 && p < 3000)
    begin
      @(posedge clk_sys);
      #1;
      p++;
    end
  endtask

  initial
  begin
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd_reg(rtcc_pkg::CTRL_OFS, d);
    check("ctrl reset", d, 32'h0000_0000);
    rd_reg(rtcc_pkg::FLAG_OFS, d);
    check("flag reset", d, 32'h0000_0000);
    rd_reg(8'h40, d);
    check("unmapped", d, 32'h0000_0000);
    $display("test reset done");
    // Reserved bits set on purpose: they must not stick
    // Lane 0 also carries the enable bit, so only lane 1 is sync-free
    wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_F3F8, 4'h2);
    rd_reg(rtcc_pkg::FLAG_OFS, d);
    check("busy static", d[rtcc_pkg::SYNC_BUSY_BIT], 1'b0);
    wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_F3F8, 4'h1);
    rd_reg(rtcc_pkg::CTRL_OFS, d);
    check("ctrl static", d, 32'h0000_03C8);
    check("mode out", mode, 2'h2);
    check("hour out", hour_12h, 1'b1);
    wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_0500, 4'h2);
    rd_reg(rtcc_pkg::CTRL_OFS, d);
    check("ctrl lane1", d, 32'h0000_05C8);
    guard <= 1'b1;
    wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_0000, 4'h3);
    guard <= 1'b0;
    rd_reg(rtcc_pkg::CTRL_OFS, d);
    check("ctrl guarded", d, 32'h0000_05C8);
    $display("test static fields done");
    for (int i = 0; i < 3; i++)
    begin
      wr_reg(rtcc_pkg::CTRL_OFS, {20'h0, codes[i], 8'h00}, 4'h2);
      wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_00CA, 4'h1);
      rd_reg(rtcc_pkg::FLAG_OFS, d);
      check("busy on", d[rtcc_pkg::SYNC_BUSY_BIT], 1'b1);
      check("not yet on", counter_enable, 1'b0);
      rd_reg(rtcc_pkg::CTRL_OFS, d);
      check("ctrl en", d, {20'h0, codes[i], 8'hCA});
      wait_en(1'b1);
      period(n);
      check("presc period", n, rtcc_pkg::SRC_DIV_CYC << codes[i]);
      if (i < 2)
      begin
        wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_00C8, 4'h1);
        wait_en(1'b0);
      end
    end
    $display("test enable and prescaler done");
    wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_0002, 4'h1);
    wait_en(1'b1);
    rd_reg(rtcc_pkg::CTRL_OFS, d);
    check("ctrl protected", d, 32'h0000_0ACA);
    check("mode kept", mode, 2'h2);
    rd_reg(rtcc_pkg::FLAG_OFS, d);
    check("ready flag", d[rtcc_pkg::SYNC_RDY_BIT], 1'b1);
    wr_reg(rtcc_pkg::IRQ_EN_OFS, 32'h0000_0040, 4'h1);
    repeat (2) @(posedge clk_sys);
    #1;
    check("irq on", irq, 1'b1);
    wr_reg(rtcc_pkg::IRQ_CLR_OFS, 32'h0000_0040, 4'h1);
    repeat (2) @(posedge clk_sys);
    #1;
    check("irq off", irq, 1'b0);
    $display("test protection and interrupt done");
    @(posedge clk_sys);
    match_hit <= 1'b1;
    @(posedge clk_sys);
    match_hit <= 1'b0;
    n = 0;
    repeat (3)
    begin
      #1;
      n += counter_clear;
      @(posedge clk_sys);
    end
    check("clear pulses", n, 32'h0000_0001);
    $display("test clear on match done");
    wr_reg(rtcc_pkg::FLAG_OFS, 32'h0100_0000, 4'h8);
    wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_0ACB, 4'h3);
    rd_reg(rtcc_pkg::CTRL_OFS, d);
    check("software_reset ongoing", d[0], 1'b1);
    n = 0;
    while (regs_reset !== 1'b1 && n < 20)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("regs_reset", regs_reset, 1'b1);
    rd_reg(rtcc_pkg::CTRL_OFS, d);
    check("ctrl after software_reset", d, 32'h0000_0000);
    rd_reg(rtcc_pkg::FLAG_OFS, d);
    check("busy after software_reset", d[rtcc_pkg::SYNC_BUSY_BIT], 1'b0);
    check("debug kept", debug_run, 1'b1);
    check("disabled", counter_enable, 1'b0);
    $display("test software reset done");
    wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_0044, 4'h1);
    #1;
    check("mode narrow", mode, 2'h1);
    check("hour outside cal", hour_12h, 1'b0);
    $display("test narrow mode done");
    // A sync write made while busy is held and replayed afterwards
    wr_reg(rtcc_pkg::CTRL_OFS, 32'h0000_0006, 4'h1);
    wait_en(1'b1);
    rd_reg(rtcc_pkg::FLAG_OFS, d);
    check("busy replay", d[rtcc_pkg::SYNC_BUSY_BIT], 1'b1);
    rd_reg(rtcc_pkg::CTRL_OFS, d);
    check("ctrl replay", d, 32'h0000_0006);
    $display("test replayed enable done");
    summarize();
  end
endmodule // rtcc_ctrl_tb
